// >>> rtl/spi_cfg_device.sv
`timescale 1ns/1ps
module spi_cfg_device
	import spi_cfg_pkg::*;
#(
	parameter int NUM_REGS = NREG
) (
	// System
	input wire logic core_clk,
	input wire logic srst,
	// Serial link
	spi_cfg_if.device link,
	// Pattern generator side
	input wire logic gen_idle,
	input wire logic [MEM_AW-1:0] pat_rd_addr,
	output logic [MEM_W-1:0] pat_rd_data,
	output logic [NUM_REGS-1:0][WORD_W-1:0] active_regs,
	output logic update_armed
);
	typedef struct packed {
		logic [1:0] sclk_s;
		logic sclk_d;
		logic [1:0] cs_s;
		logic [1:0] rst_s;
		logic [1:0] sdio_s;
		logic [1:0] sdi2_s;
		phase_e ph;
		logic rw;
		logic [CNT_W-1:0] cnt;
		logic [WORD_W-1:0] rx;
		logic [WORD_W-1:0] tx;
		logic [ADDR_W-1:0] addr;
		logic out_bit;
		logic drive;
		logic armed;
		logic [NUM_REGS-1:0][WORD_W-1:0] shadow;
		logic [NUM_REGS-1:0][WORD_W-1:0] active;
		logic [MEM_W-1:0] pat_q;
	} state_s;
	state_s r, n;
	logic [MEM_W-1:0] mem [MEM_DEPTH];
	logic mem_we;
	logic [MEM_AW-1:0] mem_wa;
	logic [MEM_W-1:0] mem_wd;
	logic rise, fall, sel, hdr, four, dual, dual_wr;
	logic hdr_done, word_done, wr_word, xfer_now;
	logic hit_mem, hit_xfer, hit_reg;
	logic [ADDR_W-1:0] rd_a;
	logic [WORD_W-1:0] rd_word, rx_n;
	logic [CNT_W-1:0] cnt_n;

	// Pattern memory window of the serial map
	function automatic logic in_mem(input logic [ADDR_W-1:0] a);
		return a >= MEM_BASE && a <= MEM_LAST;
	endfunction

	assign rise = r.sclk_s[1] & ~r.sclk_d;
	assign fall = ~r.sclk_s[1] & r.sclk_d;
	assign sel = ~r.cs_s[1];
	assign hdr = r.ph != PH_DATA;
	// The mode register takes effect at once, without the shadow step
	assign four = r.shadow[MODE_ADDR][MODE_FOUR_WIRE_BIT];
	assign dual = r.shadow[MODE_ADDR][MODE_DUAL_BIT];
	assign dual_wr = dual && !hdr && r.rw != RW_READ;
	assign cnt_n = r.cnt + (dual_wr ? 5'h02 : 5'h01);
	// Dual writes take the data line first, then the shared pin
	assign rx_n = dual_wr ? {r.rx[WORD_W-3:0], r.sdio_s[1], r.sdi2_s[1]}
		: {r.rx[WORD_W-2:0], r.sdio_s[1]};
	assign rd_a = hdr ? {r.rx[ADDR_W-2:0], r.sdio_s[1]} : r.addr + 15'h0001;

	// Frame milestones, seen on the synchronised link clock
	assign hdr_done = rise && hdr && r.cnt == HDR_LAST;
	assign word_done = rise && !hdr && cnt_n == WORD_BITS;
	assign wr_word = word_done && r.rw != RW_READ;
	// Region of the map that the finished word belongs to
	assign hit_mem = in_mem(r.addr);
	assign hit_xfer = r.addr == XFER_ADDR;
	assign hit_reg = r.addr < ADDR_W'(NUM_REGS);
	// Copy to the active set only while the generator is off
	assign xfer_now = r.armed && gen_idle;

	always_comb begin
		rd_word = '0;
		if (in_mem(rd_a)) begin
			rd_word = WORD_W'(mem[rd_a[MEM_AW-1:0]]);
		end else if (rd_a == XFER_ADDR) begin
			rd_word[XFER_UPDATE_BIT] = r.armed;
		end else if (rd_a < ADDR_W'(NUM_REGS)) begin
			rd_word = r.shadow[rd_a[CNT_W-1:0]];
		end
	end

	always_comb begin
		n = r;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = '0;
		// Every link pin passes two flops before any logic reads it
		n.sclk_s = {r.sclk_s[0], link.sclk};
		n.cs_s = {r.cs_s[0], link.cs_n};
		n.rst_s = {r.rst_s[0], link.reset_n};
		n.sdio_s = {r.sdio_s[0], link.sdio};
		n.sdi2_s = {r.sdi2_s[0], link.shared_output_second_input};
		n.sclk_d = r.sclk_s[1];
		// A new arm in the same cycle wins over this clear
		if (xfer_now) begin
			n.active = r.shadow;
			n.armed = 1'b0;
		end
		if (!sel) begin
			n.ph = PH_IDLE;
			n.cnt = '0;
			n.drive = 1'b0;
			// No stale read bits carry into the next frame
			n.out_bit = 1'b0;
			n.tx = '0;
		end else begin
			if (r.ph == PH_IDLE) begin
				n.ph = PH_HDR;
			end
			if (rise) begin
				n.rx = rx_n;
				n.cnt = cnt_n;
			end
			if (hdr_done) begin
				n.rw = r.rx[WORD_W-2];
				n.addr = rd_a;
				n.ph = PH_DATA;
				n.cnt = '0;
				n.tx = rd_word;
			end
			if (word_done) begin
				n.cnt = '0;
				n.addr = rd_a;
				n.tx = rd_word;
			end
			if (wr_word) begin
				if (hit_mem) begin
					mem_we = 1'b1;
					mem_wa = r.addr[MEM_AW-1:0];
					mem_wd = rx_n[MEM_W-1:0];
				end else if (hit_xfer) begin
					if (rx_n[XFER_UPDATE_BIT]) begin
						n.armed = 1'b1;
					end
				end else if (hit_reg) begin
					n.shadow[r.addr[CNT_W-1:0]] = rx_n;
				end
			end
			// Read bits launch a few core cycles after the link clock falls
			if (fall && !hdr && r.rw == RW_READ) begin
				n.out_bit = r.tx[WORD_W-1];
				n.tx = r.tx << 1;
				n.drive = 1'b1;
			end
		end
		// The reset pin overrides any register or arm write of the same cycle
		if (!r.rst_s[1]) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				n.shadow[i] = REG_RESET;
				n.active[i] = REG_RESET;
			end
			n.armed = 1'b0;
		end
		// Generator read port, one cycle of latency
		n.pat_q = mem[pat_rd_addr];
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			r <= '0;
			r.cs_s <= 2'b11;
			r.rst_s <= 2'b11;
		end else begin
			r <= n;
		end
		// Pattern memory has no reset and no shadow copy
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// Write transfers never enable an output
	assign link.sdio_s_o = r.out_bit;
	assign link.sdio_s_oe = r.drive & ~four;
	assign link.sdo_o = r.out_bit;
	assign link.sdo_oe = r.drive & four & ~dual;
	assign active_regs = r.active;
	assign update_armed = r.armed;
	assign pat_rd_data = r.pat_q;
endmodule

// >>> rtl/spi_cfg_master.sv
`timescale 1ns/1ps
module spi_cfg_master
	import spi_cfg_pkg::*;
#(
	parameter int HALF = SCLK_HALF_DEF,
	parameter int DEPTH = FIFO_DEPTH
) (
	// System
	input wire logic core_clk,
	input wire logic srst,
	// Serial link
	spi_cfg_if.master link,
	// Command
	input wire logic start,
	input wire logic rw,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [15:0] nwords,
	input wire logic four_wire,
	input wire logic dual,
	input wire logic dev_reset,
	output logic busy,
	// Write words
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WORD_W-1:0] wr_data,
	// Read words
	output logic rd_valid,
	output logic [WORD_W-1:0] rd_data
);
	typedef struct packed {
		logic [7:0] div;
		logic sclk;
		logic cs_n;
		logic rst_n;
		phase_e ph;
		logic rw;
		logic four;
		logic dual;
		logic [CNT_W-1:0] cnt;
		logic [WORD_W-1:0] sh;
		logic [WORD_W-1:0] rx;
		logic [15:0] words;
		logic moe;
		logic m2oe;
		logic [1:0] sdio_s;
		logic [1:0] sdo_s;
		logic rd_valid;
	} state_s;
	state_s r, n;
	logic f_valid, f_pop;
	logic [WORD_W-1:0] f_data;
	logic tick, din, wr_data_ph;
	logic [CNT_W-1:0] step, cnt_n;

	word_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) word_fifo_i (
		.core_clk(core_clk),
		.srst(srst),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_data),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);

	assign tick = r.div == 8'(HALF - 1);
	assign wr_data_ph = r.ph == PH_DATA && r.rw != RW_READ;
	assign step = (wr_data_ph && r.dual) ? 5'h02 : 5'h01;
	assign cnt_n = r.cnt + step;
	assign din = r.four ? r.sdo_s[1] : r.sdio_s[1];
	// Next word leaves the FIFO on the falling edge that starts it
	assign f_pop = tick && r.sclk && wr_data_ph && r.cnt == '0 && f_valid;

	always_comb begin
		n = r;
		n.sdio_s = {r.sdio_s[0], link.sdio};
		n.sdo_s = {r.sdo_s[0], link.shared_output_second_input};
		n.rst_n = ~dev_reset;
		n.rd_valid = 1'b0;
		n.div = tick ? '0 : r.div + 8'h01;
		case (r.ph)
			PH_IDLE: begin
				n.div = '0;
				if (start) begin
					n.cs_n = 1'b0;
					n.ph = PH_HDR;
					n.sh = {rw, addr};
					n.rw = rw;
					n.four = four_wire;
					n.dual = dual;
					n.words = nwords;
					n.cnt = '0;
					n.moe = 1'b1;
					n.m2oe = dual & (rw != RW_READ);
				end
			end
			PH_HDR, PH_DATA: begin
				if (tick && !r.sclk) begin
					n.sclk = 1'b1;
					n.rx = {r.rx[WORD_W-2:0], din};
					n.cnt = cnt_n;
					if (cnt_n == WORD_BITS) begin
						n.cnt = '0;
						if (r.ph == PH_HDR) begin
							n.ph = (r.words == '0) ? PH_END : PH_DATA;
						end else begin
							n.rd_valid = r.rw == RW_READ;
							n.words = r.words - 16'h0001;
							if (r.words == 16'h0001) begin
								n.ph = PH_END;
							end
						end
					end
				end else if (tick && r.sclk) begin
					if (wr_data_ph && r.cnt == '0) begin
						// Hold the clock high until the FIFO has a word
						if (f_valid) begin
							n.sclk = 1'b0;
							n.sh = f_data;
						end
					end else begin
						n.sclk = 1'b0;
						n.sh = r.sh << step;
						if (r.ph == PH_DATA && r.rw == RW_READ) begin
							n.moe = 1'b0;
						end
					end
				end
			end
			PH_END: begin
				if (tick) begin
					if (r.sclk) begin
						n.sclk = 1'b0;
					end else if (!r.cs_n) begin
						n.cs_n = 1'b1;
						n.moe = 1'b0;
						n.m2oe = 1'b0;
					end else begin
						// A half period deselected lets the device release the data line
						n.ph = PH_IDLE;
					end
				end
			end
			default: begin
				n.ph = PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			r <= '0;
			r.cs_n <= 1'b1;
			r.rst_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign busy = r.ph != PH_IDLE;
	assign rd_valid = r.rd_valid;
	assign rd_data = r.rx;
	assign link.sclk = r.sclk;
	assign link.cs_n = r.cs_n;
	assign link.reset_n = r.rst_n;
	assign link.sdio_m_o = r.sh[WORD_W-1];
	assign link.sdio_m_oe = r.moe;
	assign link.sdi2_o = r.sh[WORD_W-2];
	assign link.sdi2_oe = r.m2oe;
endmodule

// >>> rtl/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// System
	input wire logic core_clk,
	input wire logic srst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} state_s;
	state_s r, n;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	assign in_ready = r.cnt != (AW+1)'(DEPTH);
	assign out_valid = r.cnt != '0;
	assign out_data = mem[r.rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		n = r;
		if (push) begin
			n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
		end
		if (pop) begin
			n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
		end
		n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			r <= '0;
		end else begin
			r <= n;
		end
		if (push) begin
			mem[r.wp] <= in_data;
		end
	end
endmodule

// >>> shared/spi_cfg_if.sv
`timescale 1ns/1ps
interface spi_cfg_if;
	logic sclk;
	logic cs_n;
	logic reset_n;
	logic sdio_m_o;
	logic sdio_m_oe;
	logic sdio_s_o;
	logic sdio_s_oe;
	logic sdo_o;
	logic sdo_oe;
	logic sdi2_o;
	logic sdi2_oe;
	logic sdio;
	logic shared_output_second_input;
	// Wire levels resolved from the enables, pulled high when undriven
	assign sdio = sdio_m_oe ? sdio_m_o : (sdio_s_oe ? sdio_s_o : 1'b1);
	assign shared_output_second_input = sdo_oe ? sdo_o : (sdi2_oe ? sdi2_o : 1'b1);
	modport master (output sclk, output cs_n, output reset_n, output sdio_m_o,
		output sdio_m_oe, output sdi2_o, output sdi2_oe, input sdio,
		input shared_output_second_input);
	modport device (input sclk, input cs_n, input reset_n, output sdio_s_o,
		output sdio_s_oe, output sdo_o, output sdo_oe, input sdio,
		input shared_output_second_input);
endinterface

// >>> shared/spi_cfg_pkg.sv
package spi_cfg_pkg;
	localparam int ADDR_W = 15;
	localparam int WORD_W = 16;
	localparam int MEM_W = 12;
	localparam int MEM_AW = 12;
	localparam int MEM_DEPTH = 4096;
	localparam int NREG = 32;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] WORD_BITS = 5'h10;
	localparam logic [CNT_W-1:0] HDR_LAST = 5'h0f;
	localparam logic [ADDR_W-1:0] MEM_BASE = 15'h6000;
	localparam logic [ADDR_W-1:0] MEM_LAST = 15'h6fff;
	localparam logic [ADDR_W-1:0] MODE_ADDR = 15'h0000;
	localparam logic [ADDR_W-1:0] XFER_ADDR = 15'h001d;
	localparam int MODE_FOUR_WIRE_BIT = 0;
	localparam int MODE_DUAL_BIT = 1;
	localparam int XFER_UPDATE_BIT = 0;
	localparam logic [WORD_W-1:0] REG_RESET = 16'h0000;
	localparam logic RW_READ = 1'b1;
	// A read bit takes six core cycles from the falling link edge to the master's sampler
	localparam int SCLK_HALF_DEF = 6;
	localparam int FIFO_DEPTH = 8;
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_HDR = 2'b01,
		PH_DATA = 2'b10,
		PH_END = 2'b11
	} phase_e;
endpackage

// >>> sim/spi_cfg_link_properties.sv
`timescale 1ns/1ps
module spi_cfg_link_properties (
	// System
	input wire logic core_clk,
	input wire logic srst,
	// Link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_m_oe,
	input wire logic sdio_s_oe,
	input wire logic sdo_oe,
	input wire logic sdi2_oe
);
	logic sclk_q_r, cs_q_r;
	logic [5:0] rises_r;
	// Counts link clock rises since the last frame start, saturating
	always_ff @(posedge core_clk) begin
		sclk_q_r <= sclk;
		cs_q_r <= cs_n;
		if (srst || (cs_q_r && !cs_n))
			rises_r <= 6'h00;
		else if (sclk && !sclk_q_r && rises_r != 6'h3f)
			rises_r <= rises_r + 6'h01;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	a_quiet_deselect: assert property (cs_n [*5] |-> !sdio_s_oe && !sdo_oe)
		else $error("device drives while deselected");
	a_master_release: assert property (cs_n [*2] |-> !sdio_m_oe && !sdi2_oe && !sclk)
		else $error("master active while deselected");
	a_header_launch: assert property ($fell(cs_n) |-> sdio_m_oe ##0 !sclk [*5])
		else $error("header not launched cleanly");
	a_sclk_half: assert property ($rose(sclk) |-> sclk [*5])
		else $error("link clock high too short");
	a_no_clash: assert property (sdio_s_oe |-> !sdio_m_oe)
		else $error("both ends drive the data line");
	a_dual_quiet: assert property (sdi2_oe |-> !sdo_oe)
		else $error("both ends drive the shared pin");
	a_read_after_hdr: assert property (sdio_s_oe || sdo_oe |-> rises_r >= 6'h10)
		else $error("device drives inside the header");
	a_four_wire_split: assert property (sdo_oe |-> !sdio_s_oe)
		else $error("read data on both pins");
	c_three_wire: cover property (sdio_s_oe);
	c_four_wire: cover property (sdo_oe);
	c_dual: cover property (sdi2_oe);
endmodule

// >>> sim/spi_config_sram_port_tb.sv
`timescale 1ns/1ps
module spi_config_sram_port_tb;
	import spi_cfg_pkg::*;
	localparam logic [15:0] KA = 16'h9c3a;
	localparam logic [15:0] KB = 16'h5e71;
	logic core_clk = 1'b0, srst = 1'b1, start = 1'b0, rw = 1'b0, four_wire = 1'b0;
	logic dual = 1'b0, dev_reset = 1'b0, wr_valid = 1'b0, gen_idle = 1'b0;
	logic [ADDR_W-1:0] addr = 15'h0000;
	logic [15:0] nwords = 16'h0000, hdr = 16'h0000;
	logic [WORD_W-1:0] wr_data = 16'h0000;
	logic [MEM_AW-1:0] pat_rd_addr = 12'h000;
	logic busy, wr_ready, rd_valid, update_armed;
	logic [WORD_W-1:0] rd_data;
	logic [MEM_W-1:0] pat_rd_data;
	logic [NREG-1:0][WORD_W-1:0] active_regs;
	logic [WORD_W-1:0] got[$];
	int nbits = 0, error_cnt = 0, checks_done = 0, cyc = 0;
	spi_cfg_if link ();
	spi_cfg_master spi_cfg_master_i (.core_clk(core_clk), .srst(srst), .link(link.master),
		.start(start), .rw(rw), .addr(addr), .nwords(nwords), .four_wire(four_wire),
		.dual(dual), .dev_reset(dev_reset), .busy(busy), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data));
	spi_cfg_device spi_cfg_device_i (.core_clk(core_clk), .srst(srst), .link(link.device),
		.gen_idle(gen_idle), .pat_rd_addr(pat_rd_addr), .pat_rd_data(pat_rd_data),
		.active_regs(active_regs), .update_armed(update_armed));
	spi_cfg_link_properties spi_cfg_link_properties_i (.core_clk(core_clk), .srst(srst),
		.sclk(link.sclk), .cs_n(link.cs_n), .sdio_m_oe(link.sdio_m_oe),
		.sdio_s_oe(link.sdio_s_oe), .sdo_oe(link.sdo_oe), .sdi2_oe(link.sdi2_oe));
	always #2.5 core_clk = ~core_clk;
	// Keeps the first sixteen wire bits of each frame
	always @(negedge link.cs_n) nbits = 0;
	always @(posedge link.sclk) begin
		if (nbits < 16)
			hdr = {hdr[14:0], link.sdio};
		nbits++;
	end
	function automatic logic [15:0] pat(input logic [15:0] k, input int i);
		return k ^ (16'(i) * 16'h1111);
	endfunction
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input logic r, input logic [14:0] a, input int n, input logic fw,
			input logic du);
		int k;
		got.delete();
		start <= 1'b1;
		rw <= r;
		addr <= a;
		nwords <= 16'(n);
		four_wire <= fw;
		dual <= du;
		@(posedge core_clk);
		start <= 1'b0;
		k = 0;
		do begin
			@(negedge core_clk);
			if (rd_valid === 1'b1)
				got.push_back(rd_data);
			k++;
		end while (busy !== 1'b0 && k < 9000);
		check(hdr, {r, a});
		check({14'h0000, link.cs_n, link.sclk}, 16'h0002);
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [14:0] a, input int n, input logic [15:0] k, input logic du);
		for (int i = 0; i < n; i++) begin
			wr_valid <= 1'b1;
			wr_data <= pat(k, i);
			do
				@(posedge core_clk);
			while (wr_ready !== 1'b1);
		end
		wr_valid <= 1'b0;
		if (n == FIFO_DEPTH) begin
			@(posedge core_clk);
			check({15'h0000, wr_ready}, 16'h0000);
		end
		cmd(1'b0, a, n, 1'b0, du);
	endtask
	task automatic rd(input logic [14:0] a, input int n, input logic fw, input logic [15:0] k,
			input int off, input int nz);
		cmd(1'b1, a, n, fw, 1'b0);
		check(16'(got.size()), 16'(n));
		foreach (got[i])
			check(got[i], i < nz ? pat(k, off + i) : 16'h0000);
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		// Full buffer burst into consecutive registers, then read back
		wr(15'h0001, 8, KA, 1'b0);
		rd(15'h0001, 8, 1'b0, KA, 0, 8);
		// Burst running past the register space into unmapped addresses
		wr(15'h001e, 2, KB, 1'b0);
		rd(15'h001e, 3, 1'b0, KB, 0, 2);
		// Four-wire read
		wr(MODE_ADDR, 1, 16'h0001, 1'b0);
		rd(15'h0005, 2, 1'b1, KA, 4, 2);
		// Armed update waits for the generator to go idle
		wr(XFER_ADDR, 1, 16'h0001, 1'b0);
		check({15'h0000, update_armed}, 16'h0001);
		repeat (40) @(posedge core_clk);
		check(active_regs[3], 16'h0000);
		gen_idle <= 1'b1;
		repeat (4) @(posedge core_clk);
		check(active_regs[3], pat(KA, 2));
		gen_idle <= 1'b0;
		// Dual-lane fill of the last two pattern memory words
		wr(MODE_ADDR, 1, 16'h0002, 1'b0);
		wr(MEM_LAST - 15'h0001, 2, KB, 1'b1);
		for (int i = 0; i < 2; i++) begin
			pat_rd_addr <= 12'hffe + 12'(i);
			repeat (3) @(posedge core_clk);
			check({4'h0, pat_rd_data}, 16'h0fff & pat(KB, i));
		end
		// Dual mode keeps the shared pin undriven even in a four-wire read
		wr(MODE_ADDR, 1, 16'h0003, 1'b1);
		cmd(1'b1, 15'h0003, 1, 1'b1, 1'b0);
		check(16'(got.size()), 16'h0001);
		check(got[0], 16'hffff);
		// Reset pin restores defaults
		dev_reset <= 1'b1;
		repeat (8) @(posedge core_clk);
		dev_reset <= 1'b0;
		repeat (8) @(posedge core_clk);
		check(active_regs[3], 16'h0000);
		rd(15'h0003, 1, 1'b0, KA, 0, 0);
		end_of_test();
	end
endmodule
